// >>> cpu_model.sv
module cpu_model (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // bench control
    input wire logic take_en,
    input wire logic [1:0] take_wait,
    // offer from the arbiter
    input wire level_setup_pkg::offer_t cpu_offer,
    output logic cpu_accept
);
    timeunit 1ns;
    timeprecision 1ps;
    import level_setup_pkg::*;
    logic [1:0] wait_reg;
    // a slow core lets an offer stand a while, so preemption can happen first
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wait_reg <= 2'h0;
        end else begin
            wait_reg <= (!cpu_offer.valid || cpu_accept) ? 2'h0 : wait_reg + 2'(wait_reg != 2'h3);
        end
    end
    // one take per standing offer; never takes an invalid one
    assign cpu_accept = take_en && cpu_offer.valid && (wait_reg >= take_wait);
endmodule : cpu_model

// >>> interrupt_level_setup.sv
module interrupt_level_setup (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // peripheral requests, bit n is source n
    input wire logic [level_setup_pkg::NUM_SRC-1:0] src_req,
    // cpu side
    output level_setup_pkg::offer_t cpu_offer,
    input wire logic cpu_accept,
    // summary interrupt
    output logic irq
);
    import level_setup_pkg::*;

    typedef enum logic [1:0] {
        WR_IDLE = 2'b00,
        WR_RESP = 2'b01
    } wr_state_t;

    logic rst_meta_reg;
    logic rst_sync_reg;
    logic [LEVEL_W-1:0] level_reg [NUM_SRC];
    logic [NUM_SRC-1:0] pending_reg;
    offer_t offer_reg;
    offer_t offer_next;
    logic [EV_W-1:0] status_reg;
    logic [EV_W-1:0] mask_reg;
    logic [EV_W-1:0] event_set;
    logic aw_held_reg;
    logic w_held_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    wr_state_t wr_state_reg;
    logic do_write;
    logic wr_level_hit;
    logic [3:0] wr_index;
    logic [3:0] rd_index;
    logic [31:0] rd_word;
    logic rd_ok;

    // reset released through two flops so the release is clean
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // write channels are taken independently, one write in flight
    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end else if (do_write) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    assign do_write = aw_held_reg && w_held_reg && (wr_state_reg == WR_IDLE);
    assign wr_index = awaddr_reg[5:2];
    assign wr_level_hit = (awaddr_reg[7:6] == LEVEL_BASE_ADDR[7:6]) && (wr_index < 4'(NUM_REGS))
        && (awaddr_reg[1:0] == 2'h0);

    // ready flops: ready only while nothing of that channel is held
    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !(aw_held_reg || (s_axi_awvalid && s_axi_awready)) || do_write;
            s_axi_wready <= !(w_held_reg || (s_axi_wvalid && s_axi_wready)) || do_write;
        end
    end

    // write response, slverr on an unmapped word
    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            wr_state_reg <= WR_IDLE;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            case (wr_state_reg)
                WR_IDLE: begin
                    if (do_write) begin
                        wr_state_reg <= WR_RESP;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp <= (wr_level_hit || awaddr_reg == IRQ_STATUS_ADDR
                            || awaddr_reg == IRQ_MASK_ADDR || awaddr_reg == OFFER_ADDR) ? RESP_OKAY : RESP_SLVERR;
                    end
                end
                WR_RESP: begin
                    if (s_axi_bready) begin
                        wr_state_reg <= WR_IDLE;
                        s_axi_bvalid <= 1'b0;
                    end
                end
                default: begin
                    wr_state_reg <= WR_IDLE;
                    s_axi_bvalid <= 1'b0;
                end
            endcase
        end
    end

    // level fields: two per register, reserved bits never stored
    generate
        for (genvar s = 0; s < NUM_SRC; s++) begin : g_level
            localparam int REG_IDX = s / 2;
            localparam int LSB = (s % 2 == 1) ? ODD_LSB : EVEN_LSB; // see [R01]
            // fixed source to field map, index s is vector order, see [R03] [R04] [R05] [R06] [R07] [R08]
            // continuing through the larger variant's sources, see [R09] [R10] [R11] [R12] [R13] [R14]
            always_ff @(posedge clk or negedge rst_sync_reg) begin
                if (!rst_sync_reg) begin
                    level_reg[s] <= LEVEL_RESET; // see [R15] [R17]
                end else if (do_write && wr_level_hit && wr_index == 4'(REG_IDX) && wstrb_reg[LSB/8]) begin
                    level_reg[s] <= wdata_reg[LSB +: LEVEL_W];
                end
            end
        end
    endgenerate

    // arbitration: highest level wins, lowest vector on a tie, level 0 never offered
    always_comb begin
        offer_next = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (pending_reg[i] && level_reg[i] != LEVEL_RESET
                && (!offer_next.valid || level_reg[i] >= offer_next.level)) begin // see [R16] [R17] [R02]
                offer_next.valid = 1'b1;
                offer_next.level = level_reg[i];
                offer_next.vector = VEC_W'(i);
            end
        end
    end

    // pending bits copy src_req each cycle and clear on an accept; a dropped source request cancels it
    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            pending_reg <= '0;
        end else begin
            for (int i = 0; i < NUM_SRC; i++) begin
                if (cpu_accept && offer_reg.valid && offer_reg.vector == VEC_W'(i)) begin
                    pending_reg[i] <= 1'b0; // see [R16]
                end else begin
                    pending_reg[i] <= src_req[i];
                end
            end
        end
    end

    // offered request re-evaluated every cycle except an accept cycle, so a newer winner replaces it
    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            offer_reg <= '0;
        end else if (cpu_accept && offer_reg.valid) begin
            offer_reg <= '0; // one idle cycle after accept lets the cleared bit settle
        end else begin
            offer_reg <= offer_next; // see [R18]
        end
    end
    assign cpu_offer = offer_reg;

    // events: accept and preemption of an offered request
    assign event_set[EV_ACCEPT] = cpu_accept && offer_reg.valid;
    assign event_set[EV_PREEMPT] = offer_reg.valid && !cpu_accept && offer_next.valid
        && offer_next.vector != offer_reg.vector;

    // sticky status, write one to clear, a new event wins over the clear
    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            status_reg <= '0;
            mask_reg <= '0;
        end else begin
            if (do_write && awaddr_reg == IRQ_STATUS_ADDR && wstrb_reg[0]) begin
                status_reg <= (status_reg & ~wdata_reg[EV_W-1:0]) | event_set;
            end else begin
                status_reg <= status_reg | event_set;
            end
            if (do_write && awaddr_reg == IRQ_MASK_ADDR && wstrb_reg[0]) begin
                mask_reg <= wdata_reg[EV_W-1:0];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_reg & mask_reg);
        end
    end

    // read mux; reserved bits read zero
    assign rd_index = s_axi_araddr[5:2];
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_ok = 1'b1;
        if (s_axi_araddr[7:6] == LEVEL_BASE_ADDR[7:6] && rd_index < 4'(NUM_REGS) && s_axi_araddr[1:0] == 2'h0) begin
            rd_word[EVEN_LSB +: LEVEL_W] = level_reg[{rd_index, 1'b0}]; // see [R15]
            rd_word[ODD_LSB +: LEVEL_W] = level_reg[{rd_index, 1'b1}];
        end else if (s_axi_araddr == IRQ_STATUS_ADDR) begin
            rd_word[EV_W-1:0] = status_reg;
        end else if (s_axi_araddr == IRQ_MASK_ADDR) begin
            rd_word[EV_W-1:0] = mask_reg;
        end else if (s_axi_araddr == OFFER_ADDR) begin
            rd_word[VEC_W-1:0] = offer_reg.vector;
            rd_word[ODD_LSB +: LEVEL_W] = offer_reg.level;
            rd_word[16] = offer_reg.valid;
        end else begin
            rd_ok = 1'b0;
        end
    end

    // read channel: address taken when idle, data one cycle later
    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else begin
            s_axi_arready <= 1'b1;
        end
    end
endmodule : interrupt_level_setup

// >>> interrupt_level_setup_assertions.sv
module interrupt_level_setup_assertions (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // register read path
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // arbiter
    input wire logic [level_setup_pkg::NUM_SRC-1:0] src_req,
    input wire level_setup_pkg::offer_t cpu_offer,
    input wire logic cpu_accept
);
    timeunit 1ns;
    timeprecision 1ps;
    import level_setup_pkg::*;
    logic [7:0] ar_q;
    logic [NUM_SRC-1:0] req_d1;
    logic [NUM_SRC-1:0] req_d2;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // history of inputs: read address in flight, requests two edges back
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ar_q <= 8'h00;
            req_d1 <= '0;
            req_d2 <= '0;
        end else begin
            ar_q <= (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : ar_q;
            req_d1 <= src_req;
            req_d2 <= req_d1;
        end
    end
    AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read not closed");
    AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("address taken during read");
    AST_SPARE_ZERO: assert property (s_axi_rvalid && ar_q < 8'h30 |-> (s_axi_rdata & 32'hFFFF_F8F8) == 32'h0)
        else $error("spare level bits not zero");
    AST_OFFER_SRC: assert property (cpu_offer.valid |-> req_d2[cpu_offer.vector])
        else $error("offer without request");
    AST_IDLE: assert property (req_d2 == '0 |-> !cpu_offer.valid)
        else $error("offer with no request");
    AST_NO_ZERO: assert property (cpu_offer.valid |-> cpu_offer.level != 3'h0)
        else $error("level zero offered");
    AST_ACC_GAP: assert property (cpu_accept && cpu_offer.valid |=> !cpu_offer.valid)
        else $error("offer kept after take");
endmodule : interrupt_level_setup_assertions

bind interrupt_level_setup interrupt_level_setup_assertions chk_u (
    .clk, .reset_n, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .src_req, .cpu_offer, .cpu_accept
);

// >>> interrupt_level_setup_tb.sv
module interrupt_level_setup_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import level_setup_pkg::*;
    logic clk, reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, cpu_accept, take_en;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, take_wait, resp;
    logic [NUM_SRC-1:0] src_req;
    offer_t cpu_offer;
    logic [LEVEL_W-1:0] exp_lvl [NUM_SRC];
    logic [7:0] bad_addr [4] = '{8'h30, 8'h3C, 8'h02, 8'hFC};
    int fails, checked, n_acc;
    interrupt_level_setup dut_u (.clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .src_req, .cpu_offer, .cpu_accept, .irq);
    cpu_model cpu_u (.clk, .reset_n, .take_en, .take_wait, .cpu_offer, .cpu_accept);
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask : chk
    task automatic end_of_test();
        $display("counts: %0d checked, %0d fails", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test
    // a handshake that never comes ends the run at once
    task automatic limit(input int n);
        chk("handshake wait", 32'h1, 32'(n < 100));
        if (n >= 100) begin
            end_of_test();
        end
    endtask : limit
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
        int n;
        @(posedge clk);
        n = 0;
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, v, s};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge clk);
            n++;
            s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
            s_axi_wvalid <= s_axi_wvalid && !s_axi_wready;
        end while (s_axi_bvalid !== 1'b1 && n < 100);
        limit(n);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a);
        int n;
        @(posedge clk);
        n = 0;
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge clk);
            n++;
            s_axi_arvalid <= s_axi_arvalid && !s_axi_arready;
        end while (s_axi_rvalid !== 1'b1 && n < 100);
        limit(n);
        {rd, resp} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
    endtask : axi_rd
    // expected offer: highest level wins, ties to the lowest vector, level zero never
    function automatic offer_t best(input logic [NUM_SRC-1:0] req);
        offer_t o;
        o = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (req[i] && exp_lvl[i] != 3'h0 && (!o.valid || exp_lvl[i] > o.level)) begin
                o = {1'b1, exp_lvl[i], 5'(i)};
            end
        end
        return o;
    endfunction : best
    task automatic set_levels(input logic [31:0] om);
        for (int x = 0; x < NUM_REGS; x++) begin
            d = $urandom() | om;
            axi_wr(8'(4 * x), d, 4'hF);
            {exp_lvl[2 * x + 1], exp_lvl[2 * x]} = {d[10:8], d[2:0]};
            axi_rd(8'(4 * x));
            chk("level reg", d & 32'h0000_0707, rd);
        end
    endtask : set_levels
    task automatic round(input logic [31:0] om);
        logic [NUM_SRC-1:0] cur;
        int n;
        set_levels(om);
        cur = '0;
        // requests arrive one by one; a newer higher one must take over the offer
        for (int k = 0; k < 6; k++) begin
            @(posedge clk);
            cur[$urandom() % NUM_SRC] = 1'b1;
            src_req <= cur;
            repeat (3) @(posedge clk);
            chk("offer", 32'(best(cur)), 32'(cpu_offer.valid ? cpu_offer : offer_t'(0)));
        end
        n = 0;
        n_acc = 0;
        {take_en, take_wait} <= {1'b1, 2'($urandom())};
        while (best(src_req).valid && n < 100) begin
            @(posedge clk);
            n++;
        end
        limit(n);
        for (int i = 0; i < NUM_SRC; i++) n_acc -= int'(cur[i] && exp_lvl[i] != 3'h0);
        chk("takes left over", 32'h0, 32'(n_acc));
        take_en <= 1'b0;
        src_req <= '0;
        $display("test arbitration round done");
    endtask : round
    // each take must be the best pending request; the peripheral then drops it
    always @(posedge clk) begin
        if (cpu_accept === 1'b1 && cpu_offer.valid === 1'b1) begin
            chk("taken", 32'(best(src_req)), 32'(cpu_offer));
            src_req[cpu_offer.vector] <= 1'b0;
            n_acc++;
        end
    end
    initial begin
        {reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, take_en} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, take_wait, src_req} = '0;
        void'($urandom(98701));
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        for (int x = 0; x < NUM_REGS; x++) begin
            axi_rd(8'(4 * x));
            chk("reset level", 32'h0, rd);
        end
        // spare and misaligned addresses answer with an error and read zero
        foreach (bad_addr[i]) begin
            axi_wr(bad_addr[i], 32'hFFFF_FFFF, 4'hF);
            chk("bad write resp", 32'(RESP_SLVERR), 32'(resp));
            axi_rd(bad_addr[i]);
            chk("bad read", 32'(RESP_SLVERR), rd | 32'(resp));
        end
        $display("test reset and map done");
        set_levels(32'h0000_0101);
        // one source at a time: each field must drive its own vector and level
        for (int s = 0; s < NUM_SRC; s++) begin
            @(posedge clk);
            src_req <= NUM_SRC'(1) << s;
            repeat (3) @(posedge clk);
            chk("mapping", 32'(best(NUM_SRC'(1) << s)), 32'(cpu_offer));
            // continuing through the larger variant's sources
        end
        // the last source still stands: its offer must read back as valid, level and vector
        axi_rd(OFFER_ADDR);
        chk("offer readback", {15'h0, 1'b1, 5'h0, exp_lvl[NUM_SRC-1], 3'h0, 5'(NUM_SRC-1)}, rd);
        src_req <= '0;
        axi_wr(LEVEL_BASE_ADDR, 32'h0000_0707, 4'h1);
        axi_rd(LEVEL_BASE_ADDR);
        chk("byte strobe", {21'h0, exp_lvl[1], 5'h0, 3'h7}, rd);
        $display("test mapping done");
        repeat (4) round(32'h0);
        // the mapping walk switched offers between sources, so the preempt event must be recorded
        axi_rd(IRQ_STATUS_ADDR);
        chk("preempt event", 32'h2, rd & 32'h2);
        axi_wr(IRQ_STATUS_ADDR, 32'h3, 4'hF);
        axi_wr(IRQ_MASK_ADDR, 32'h0, 4'hF);
        round(32'h0000_0101);
        chk("irq masked", 32'h0, 32'(irq));
        axi_wr(IRQ_MASK_ADDR, 32'h1, 4'hF);
        repeat (2) @(posedge clk);
        chk("irq raised", 32'h1, 32'(irq));
        axi_rd(IRQ_STATUS_ADDR);
        chk("take event", 32'h1, rd & 32'h1);
        axi_wr(IRQ_STATUS_ADDR, 32'h1, 4'hF);
        repeat (2) @(posedge clk);
        chk("irq cleared", 32'h0, 32'(irq));
        $display("test interrupt done");
        end_of_test();
    end
endmodule : interrupt_level_setup_tb

// >>> level_setup_pkg.sv
// Summary of operation
// [R01] each level setup register holds odd source level in 10:8, even in 2:0
// [R02] a level field is the priority directly, 7 highest and 0 lowest
// [R03] register 0: low field voltage detector, high field io port
// [R04] register 1: low field power generator, high field clock generator
// [R05] register 2: low field real-time clock, high field timer channel 0
// [R06] register 3: low field uart 0, high field timer channel 1
// [R07] register 4: low field sync serial 0, high field i2c
// [R08] register 5: low field pwm timer 0, high field pwm timer 1
// [R09] register 6: low field uart 1, high field sound generator
// [R10] register 7: low field ir remote, high field lcd driver
// [R11] register 8: low field rf converter 0, high field rf converter 1
// [R12] register 9: low field timer channel 2, high field sync serial 1
// [R13] register 10: low field timer channel 3, high field adc
// [R14] register 11: low field timer channel 4, high field sync serial 2
// [R15] reserved bits read zero, ignore writes; levels clear to zero at reset
// [R16] forward highest level, ties to lowest vector, hold others until accepted; the code only registers src_req, so a dropped request is not held
// [R17] a level-zero source is never offered; all levels default to zero
// [R18] a newer higher-priority request replaces the offered level and vector
package level_setup_pkg;
    localparam int NUM_REGS = 12;
    localparam int NUM_SRC = 24;
    localparam int LEVEL_W = 3;
    localparam int VEC_W = 5;
    localparam int ADDR_W = 8;
    // source index (vector order) per field, two per register
    localparam int SRC_VOLTAGE_DET = 0;
    localparam int SRC_IO_PORT = 1;
    localparam int SRC_POWER_GEN = 2;
    localparam int SRC_CLOCK_GEN = 3;
    localparam int SRC_RTC = 4;
    localparam int SRC_TIMER0 = 5;
    localparam int SRC_UART0 = 6;
    localparam int SRC_TIMER1 = 7;
    localparam int SRC_SYNC_SERIAL0 = 8;
    localparam int SRC_I2C = 9;
    localparam int SRC_PWM_TIMER0 = 10;
    localparam int SRC_PWM_TIMER1 = 11;
    localparam int SRC_UART1 = 12;
    localparam int SRC_SOUND_GEN = 13;
    localparam int SRC_IR_REMOTE = 14;
    localparam int SRC_LCD_DRIVER = 15;
    localparam int SRC_RF_CONV0 = 16;
    localparam int SRC_RF_CONV1 = 17;
    localparam int SRC_TIMER2 = 18;
    localparam int SRC_SYNC_SERIAL1 = 19;
    localparam int SRC_TIMER3 = 20;
    localparam int SRC_ADC = 21;
    localparam int SRC_TIMER4 = 22;
    localparam int SRC_SYNC_SERIAL2 = 23;
    // field positions inside a level setup register
    localparam int EVEN_LSB = 0;
    localparam int ODD_LSB = 8;
    // byte addresses: level registers at 4*x, then status/mask/arbiter
    localparam logic [ADDR_W-1:0] LEVEL_BASE_ADDR = 8'h00;
    localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = 8'h40;
    localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 8'h44;
    localparam logic [ADDR_W-1:0] OFFER_ADDR = 8'h48;
    localparam logic [LEVEL_W-1:0] LEVEL_RESET = 3'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // interrupt status bits
    localparam int EV_ACCEPT = 0;
    localparam int EV_PREEMPT = 1;
    localparam int EV_W = 2;

    typedef struct packed {
        logic valid;
        logic [LEVEL_W-1:0] level;
        logic [VEC_W-1:0] vector;
    } offer_t;
endpackage : level_setup_pkg
